// ===== core/tni_pkg.sv
// Package of constants and types for the tinnitus noise injector
`default_nettype none
package tni_pkg;
  // Audio and gain formats
  localparam int AUDIO_W = 20;
  localparam int GAIN_W = 16;
  localparam int GAIN_FRAC = 14;
  localparam int LFSR_W = 23;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h5a5a5a;
  // Sample and clock rates
  localparam int CLK_HZ = 125_000_000;
  localparam int SAMPLE_HZ = 32_000;
  localparam int SAMPLES_PER_SEC = SAMPLE_HZ;
  // Duty cycle limits in seconds
  localparam logic [4:0] DUTY_MIN_S = 5'h01;
  localparam logic [4:0] DUTY_MAX_S = 5'h1e;
  // Register offsets
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_ATTEN = 4'h1;
  localparam logic [3:0] REG_LPF = 4'h2;
  localparam logic [3:0] REG_HPF = 4'h3;
  localparam logic [3:0] REG_DUTY = 4'h4;
  localparam logic [3:0] REG_VOLUME = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  // Reset values
  localparam logic [GAIN_W-1:0] ATTEN_RST = 16'h0400;
  localparam logic [GAIN_W-1:0] VOLUME_RST = 16'h4000;
  localparam logic [3:0] FILT_RST = 4'h0;
  // Insertion modes
  typedef enum logic [2:0] {
    TNI_INS_OFF = 3'h0,
    TNI_INS_PRE = 3'h1,
    TNI_INS_POST = 3'h2,
    TNI_ONLY_PRE = 3'h3,
    TNI_ONLY_POST = 3'h4,
    TNI_PRE_NOISE_VOL = 3'h5
  } tni_mode_t;
  // Duty cycle states
  typedef enum logic [1:0] {
    TNI_DUTY_CONT = 2'b00,
    TNI_DUTY_ON = 2'b01,
    TNI_DUTY_OFF = 2'b11
  } tni_duty_t;
  // Filter setting: enable and slope shift
  typedef struct packed {
    logic en;
    logic [2:0] shift;
  } tni_filt_t;
  // Audio pair carried through the buffer
  typedef struct packed {
    logic signed [AUDIO_W-1:0] pre;
    logic signed [AUDIO_W-1:0] post;
  } tni_pair_t;
endpackage
`default_nettype wire

// ===== core/tni_skid.sv
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module tni_skid
  import tni_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire tni_pair_t in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output tni_pair_t out_data
);
  tni_pair_t mem [2];
  logic wr_ptr, rd_ptr;
  logic [1:0] count;
  logic next_wr_ptr, next_rd_ptr;
  logic [1:0] next_count;
  logic push, pop;

  // Handshake terms
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  // Register pointers and storage
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  a_skid_no_overflow: assert property (@(posedge core_clk) disable iff (!resetn)
    count == 2'h2 && !out_ready |=> count == 2'h2 && $stable(out_data)) else $error("full buffer changed under stall");
endmodule
`default_nettype wire

// ===== core/tni_top.sv
// Tinnitus white noise generator and injector for the audio path
`default_nettype none
module tni_top
  import tni_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Sample input: wideband gain output and last post-filter output
  input wire logic in_valid,
  output logic in_ready,
  input wire tni_pair_t in_data,
  // Sample output: volume stage input and peak clipper input
  output logic out_valid,
  input wire logic out_ready,
  output tni_pair_t out_data,
  // Power hint
  output logic low_power
);
  // Configuration registers
  tni_mode_t mode, next_mode;
  logic [GAIN_W-1:0] atten, next_atten, volume, next_volume;
  tni_filt_t lpf, next_lpf, hpf, next_hpf;
  logic [4:0] on_s, next_on_s, off_s, next_off_s;
  logic [15:0] rdata, next_rdata;

  // Register writes
  always_comb begin
    next_mode = mode;
    next_atten = atten;
    next_volume = volume;
    next_lpf = lpf;
    next_hpf = hpf;
    next_on_s = on_s;
    next_off_s = off_s;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_MODE: begin
          if (reg_wdata[2:0] <= 3'h5) begin
            next_mode = tni_mode_t'(reg_wdata[2:0]);
          end
        end
        REG_ATTEN: next_atten = reg_wdata;
        REG_LPF: next_lpf = tni_filt_t'(reg_wdata[3:0]);
        REG_HPF: next_hpf = tni_filt_t'(reg_wdata[3:0]);
        REG_DUTY: begin
          // Clamp on time into 1..30 s
          next_on_s = (reg_wdata[4:0] < DUTY_MIN_S) ? DUTY_MIN_S :
                      (reg_wdata[4:0] > DUTY_MAX_S) ? DUTY_MAX_S : reg_wdata[4:0];
          next_off_s = (reg_wdata[12:8] > DUTY_MAX_S) ? DUTY_MAX_S : reg_wdata[12:8];
        end
        REG_VOLUME: next_volume = reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, valid in the cycle after the strobe
  logic noise_on;
  tni_duty_t duty_st;
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_MODE: next_rdata = {13'h0000, mode};
        REG_ATTEN: next_rdata = atten;
        REG_LPF: next_rdata = {12'h000, lpf};
        REG_HPF: next_rdata = {12'h000, hpf};
        REG_DUTY: next_rdata = {3'h0, off_s, 3'h0, on_s};
        REG_VOLUME: next_rdata = volume;
        REG_STATUS: next_rdata = {12'h000, low_power, duty_st, noise_on};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode <= TNI_INS_OFF;
      atten <= ATTEN_RST;
      volume <= VOLUME_RST;
      lpf <= tni_filt_t'(FILT_RST);
      hpf <= tni_filt_t'(FILT_RST);
      on_s <= DUTY_MIN_S;
      off_s <= 5'h00;
      rdata <= 16'h0000;
    end else begin
      mode <= next_mode;
      atten <= next_atten;
      volume <= next_volume;
      lpf <= next_lpf;
      hpf <= next_hpf;
      on_s <= next_on_s;
      off_s <= next_off_s;
      rdata <= next_rdata;
    end
  end
  assign reg_rdata = rdata;

  // Input buffer; a stall downstream stops sample acceptance
  tni_pair_t buf_data;
  logic buf_valid, buf_ready;
  tni_skid u_skid (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // One sample per accepted word at the system rate
  logic out_v, next_out_v;
  tni_pair_t out_q, next_out_q;
  logic take;
  assign buf_ready = !out_v || out_ready;
  assign take = buf_valid && buf_ready;

  // Noise source: maximal length LFSR stepped once per sample
  logic [LFSR_W-1:0] lfsr, next_lfsr;
  always_comb begin
    next_lfsr = lfsr;
    if (take) begin
      next_lfsr = {lfsr[LFSR_W-2:0], lfsr[22] ^ lfsr[17]};
    end
  end

  // Duty cycle timing in samples and seconds
  logic duty_wr;
  assign duty_wr = reg_wr && (reg_addr == REG_DUTY);
  logic [14:0] samp_cnt, next_samp_cnt;
  logic [4:0] sec_cnt, next_sec_cnt;
  tni_duty_t next_duty_st;
  always_comb begin
    next_duty_st = duty_st;
    next_samp_cnt = samp_cnt;
    next_sec_cnt = sec_cnt;
    if (off_s == 5'h00) begin
      next_duty_st = TNI_DUTY_CONT;
      next_samp_cnt = 15'h0000;
      next_sec_cnt = 5'h00;
    end else if (duty_wr) begin
      // New intervals restart timing, so a shorter on time cannot be overrun
      next_duty_st = TNI_DUTY_ON;
      next_samp_cnt = 15'h0000;
      next_sec_cnt = 5'h00;
    end else if (duty_st == TNI_DUTY_CONT) begin
      next_duty_st = TNI_DUTY_ON;
    end else if (take) begin
      if (samp_cnt == 15'(SAMPLES_PER_SEC - 1)) begin
        next_samp_cnt = 15'h0000;
        if (sec_cnt + 5'h01 >= ((duty_st == TNI_DUTY_ON) ? on_s : off_s)) begin
          next_sec_cnt = 5'h00;
          next_duty_st = (duty_st == TNI_DUTY_ON) ? TNI_DUTY_OFF : TNI_DUTY_ON;
        end else begin
          next_sec_cnt = sec_cnt + 5'h01;
        end
      end else begin
        next_samp_cnt = samp_cnt + 15'h0001;
      end
    end
  end
  assign noise_on = (duty_st != TNI_DUTY_OFF);

  // Noise shaping: one-pole low-pass and high-pass, slope by shift
  logic signed [AUDIO_W-1:0] white, lp_st, next_lp_st, hp_st, next_hp_st, shaped;
  logic signed [AUDIO_W-1:0] after_lp;
  logic signed [AUDIO_W:0] lp_d, hp_d;
  assign white = $signed(lfsr[LFSR_W-1 -: AUDIO_W]);
  always_comb begin
    next_lp_st = lp_st;
    next_hp_st = hp_st;
    after_lp = lpf.en ? lp_st : white;
    shaped = hpf.en ? (after_lp - hp_st) : after_lp;
    // Differences one bit wider so a full-scale step cannot wrap
    lp_d = $signed({white[AUDIO_W-1], white}) - $signed({lp_st[AUDIO_W-1], lp_st});
    hp_d = $signed({after_lp[AUDIO_W-1], after_lp}) - $signed({hp_st[AUDIO_W-1], hp_st});
    if (take) begin
      next_lp_st = lp_st + AUDIO_W'(lp_d >>> ({1'b0, lpf.shift} + 4'h1));
      next_hp_st = hp_st + AUDIO_W'(hp_d >>> ({1'b0, hpf.shift} + 4'h1));
    end
  end

  // Attenuation and volume scaling
  function automatic logic signed [AUDIO_W-1:0] scale(input logic signed [AUDIO_W-1:0] x,
                                                      input logic [GAIN_W-1:0] g);
    logic signed [AUDIO_W+GAIN_W:0] p;
    p = x * $signed({1'b0, g});
    return AUDIO_W'(p >>> GAIN_FRAC);
  endfunction

  // Saturating add to the audio width
  function automatic logic signed [AUDIO_W-1:0] sat_add(input logic signed [AUDIO_W-1:0] a,
                                                        input logic signed [AUDIO_W-1:0] b);
    logic signed [AUDIO_W:0] s;
    s = {a[AUDIO_W-1], a} + {b[AUDIO_W-1], b};
    if (s[AUDIO_W] != s[AUDIO_W-1]) begin
      return s[AUDIO_W] ? {1'b1, {(AUDIO_W-1){1'b0}}} : {1'b0, {(AUDIO_W-1){1'b1}}};
    end
    return s[AUDIO_W-1:0];
  endfunction

  logic signed [AUDIO_W-1:0] noise, noise_vol, aud_pre, aud_post;
  logic audio_en, pre_ins, post_ins, vol_on_audio;
  always_comb begin
    noise = noise_on ? scale(shaped, atten) : '0;
    noise_vol = scale(noise, volume);
    audio_en = !(mode == TNI_ONLY_PRE || mode == TNI_ONLY_POST);
    pre_ins = (mode == TNI_INS_PRE || mode == TNI_ONLY_PRE || mode == TNI_PRE_NOISE_VOL);
    post_ins = (mode == TNI_INS_POST || mode == TNI_ONLY_POST);
    vol_on_audio = (mode != TNI_PRE_NOISE_VOL);
    aud_pre = audio_en ? buf_data.pre : '0;
    aud_post = audio_en ? buf_data.post : '0;
    next_out_v = out_v && !out_ready;
    next_out_q = out_q;
    if (take) begin
      next_out_v = 1'b1;
      next_out_q.pre = aud_pre;
      next_out_q.post = aud_post;
      if (pre_ins) begin
        if (vol_on_audio) begin
          next_out_q.pre = sat_add(aud_pre, noise);
        end else begin
          // Volume stage passes audio at unity, so only noise follows volume
          next_out_q.pre = sat_add(aud_pre, noise_vol);
        end
      end
      if (post_ins) begin
        next_out_q.post = sat_add(aud_post, noise);
      end
    end
  end

  // Register generator, duty and output state
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lfsr <= LFSR_SEED;
      duty_st <= TNI_DUTY_CONT;
      samp_cnt <= 15'h0000;
      sec_cnt <= 5'h00;
      lp_st <= '0;
      hp_st <= '0;
      out_v <= 1'b0;
      out_q <= '0;
    end else begin
      lfsr <= next_lfsr;
      duty_st <= next_duty_st;
      samp_cnt <= next_samp_cnt;
      sec_cnt <= next_sec_cnt;
      lp_st <= next_lp_st;
      hp_st <= next_hp_st;
      out_v <= next_out_v;
      out_q <= next_out_q;
    end
  end
  assign out_valid = out_v;
  assign out_data = out_q;
  assign low_power = !audio_en;

  // Checks
  a_off_zero_cont: assert property (@(posedge core_clk) disable iff (!resetn)
    off_s == 5'h00 |=> duty_st == TNI_DUTY_CONT) else $error("duty cycling with zero off time");
  a_only_low_power: assert property (@(posedge core_clk) disable iff (!resetn)
    (mode == TNI_ONLY_PRE || mode == TNI_ONLY_POST) |-> low_power) else $error("noise only not low power");
  a_off_mode_pass: assert property (@(posedge core_clk) disable iff (!resetn)
    take && mode == TNI_INS_OFF |=> out_q == $past(buf_data)) else $error("audio altered with noise off");
  a_post_vol_free: assert property (@(posedge core_clk) disable iff (!resetn)
    take && mode == TNI_INS_POST |=> out_q.pre == $past(buf_data.pre)) else $error("post mode touched pre");
  a_noise_off_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    take && duty_st == TNI_DUTY_OFF && mode == TNI_ONLY_POST |=> out_q.post == '0) else $error("noise in off time");
  a_duty_on_bound: assert property (@(posedge core_clk) disable iff (!resetn)
    duty_st == TNI_DUTY_ON |-> sec_cnt < on_s) else $error("on interval overran");
  a_lfsr_steps: assert property (@(posedge core_clk) disable iff (!resetn)
    take |=> lfsr != $past(lfsr)) else $error("noise source did not advance");
  a_out_holds: assert property (@(posedge core_clk) disable iff (!resetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("output dropped under stall");
  a_sat_range: assert property (@(posedge core_clk) disable iff (!resetn)
    take && pre_ins && vol_on_audio && !aud_pre[AUDIO_W-1] && !noise[AUDIO_W-1]
    |=> !out_q.pre[AUDIO_W-1]) else $error("sum wrapped");
  a_mode_refused: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_wr && reg_addr == REG_MODE && reg_wdata[2:0] > 3'h5 |=> $stable(mode)) else $error("illegal mode taken");
  a_only_mutes_audio: assert property (@(posedge core_clk) disable iff (!resetn)
    take && mode == TNI_ONLY_PRE |=> out_q.post == '0) else $error("audio kept in noise only");
  a_vol_mutes_noise: assert property (@(posedge core_clk) disable iff (!resetn)
    take && mode == TNI_PRE_NOISE_VOL && volume == '0
    |=> out_q.pre == $past(buf_data.pre)) else $error("noise passed at zero volume");
endmodule
`default_nettype wire

// ===== verif/tni_path_model.sv
// Audio path model: sample source feeding the injector and stallable sink after it
`default_nettype none
module tni_path_model
  import tni_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Source side
  output logic in_valid,
  input wire logic in_ready,
  output tni_pair_t in_data,
  // Sink side
  input wire logic out_valid,
  output logic out_ready,
  input wire tni_pair_t out_data,
  // Stall request from the bench
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;
  tni_pair_t rx_q[$];

  // Idle source at time zero
  initial begin
    in_valid = 1'b0;
    in_data = '0;
  end

  // Sink takes a word at each edge where valid meets ready
  always @(posedge core_clk) begin
    out_ready <= !stall;
    if (resetn && out_valid && out_ready) begin
      rx_q.push_back(out_data);
    end
  end

  // Offer one word and hold it until an edge sees ready high
  task automatic push(input tni_pair_t w);
    logic ok;
    in_valid <= 1'b1;
    in_data <= w;
    do begin
      @(negedge core_clk);
      ok = in_ready;
      @(posedge core_clk);
    end while (ok !== 1'b1);
  endtask

  // Release the source; data lines stop showing the last word
  task automatic idle();
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule
`default_nettype wire

// ===== verif/tni_top_test.sv
// Self-checking bench for the tinnitus noise injector
`default_nettype none
module tni_top_test
  import tni_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready, low_power, stall;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  tni_pair_t in_data, out_data;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;

  tni_top DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .low_power(low_power));

  tni_path_model model (.core_clk(core_clk), .resetn(resetn), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .stall(stall));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic results();
    $display("Checks made %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      $display("BAD at %0t: run hung", $time);
      results();
    end
  end

  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD at %0t: %s", $time, what);
    end
  endtask

  // Register write: one cycle strobe, then one idle edge before the next request
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Register read: data judged in the cycle after the strobe, under a mask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check((reg_rdata & m) === exp, what);
    @(posedge core_clk);
  endtask

  // Send n copies of a word and wait for all of them at the sink
  task automatic xfer(input tni_pair_t w, input int n);
    int k;
    k = 0;
    model.rx_q.delete();
    for (int i = 0; i < n; i++) model.push(w);
    model.idle();
    while (model.rx_q.size() < n && k < 60) begin
      @(posedge core_clk);
      k++;
    end
    check(model.rx_q.size() == n, "word count");
  endtask

  // Lane kinds: 0 audio only, 1 audio plus noise, 2 silent, 3 noise alone
  task automatic run(input logic [2:0] mode, input logic [15:0] atten, input logic [15:0] vol,
                     input logic [1:0] kpre, input logic [1:0] kpost, input string what);
    logic [19:0] v;
    logic [1:0] k, hit;
    hit = 2'b00;
    wr(REG_MODE, {13'h0000, mode});
    wr(REG_ATTEN, atten);
    wr(REG_VOLUME, vol);
    @(negedge core_clk);
    check(low_power === (mode == 3'h3 || mode == 3'h4), what);
    @(posedge core_clk);
    xfer('{20'h7ffff, 20'h7ffff}, 16);
    foreach (model.rx_q[i]) begin
      for (int l = 0; l < 2; l++) begin
        v = l ? model.rx_q[i].post : model.rx_q[i].pre;
        k = l ? kpost : kpre;
        if (k == 2'd0) check(v === 20'h7ffff, what);
        if (k == 2'd2) check(v === 20'h00000, what);
        if (k == 2'd1) check(v[19] === 1'b0, what);
        if (v !== (k == 2'd1 ? 20'h7ffff : 20'h00000)) hit[l] = 1'b1;
      end
    end
    if (kpre[0]) check(hit[0], what);
    if (kpost[0]) check(hit[1], what);
  endtask

  // Reset values, refusals, clamping and duty state
  task automatic t_regs();
    rd(REG_MODE, 16'hffff, 16'h0000, "mode reset");
    rd(REG_ATTEN, 16'hffff, ATTEN_RST, "atten reset");
    rd(REG_LPF, 16'hffff, 16'h0000, "lpf reset");
    rd(REG_HPF, 16'hffff, 16'h0000, "hpf reset");
    rd(REG_DUTY, 16'hffff, 16'h0001, "duty reset");
    rd(REG_VOLUME, 16'hffff, VOLUME_RST, "volume reset");
    rd(REG_STATUS, 16'h000e, 16'h0000, "status reset");
    rd(4'h7, 16'hffff, 16'h0000, "unmapped read");
    wr(REG_MODE, 16'h0006);
    rd(REG_MODE, 16'hffff, 16'h0000, "bad mode taken");
    wr(REG_DUTY, 16'h1f00);
    rd(REG_DUTY, 16'hffff, 16'h1e01, "duty clamp");
    rd(REG_STATUS, 16'h0006, 16'h0002, "duty not on");
    wr(REG_DUTY, 16'h001f);
    rd(REG_DUTY, 16'hffff, 16'h001e, "on clamp");
    rd(REG_STATUS, 16'h0006, 16'h0000, "duty not continuous");
    wr(REG_DUTY, 16'h0001);
    wr(REG_LPF, 16'h000f);
    wr(REG_HPF, 16'h000b);
    rd(REG_LPF, 16'hffff, 16'h000f, "lpf setting");
    rd(REG_HPF, 16'hffff, 16'h000b, "hpf setting");
    wr(REG_LPF, 16'h0008);
  endtask

  // Duty cycling: one second of noise, then silence
  task automatic t_duty();
    logic [1:0] hit;
    hit = 2'b00;
    wr(REG_MODE, 16'h0004);
    wr(REG_DUTY, 16'h0101);
    xfer('{20'h00000, 20'h00000}, SAMPLES_PER_SEC + 4);
    for (int i = 0; i < 4; i++) begin
      if (model.rx_q[i].post !== 20'h00000) hit[0] = 1'b1;
      if (model.rx_q[SAMPLES_PER_SEC - 4 + i].post !== 20'h00000) hit[1] = 1'b1;
      check(model.rx_q[SAMPLES_PER_SEC + i].post === 20'h00000, "noise in off time");
    end
    check(hit === 2'b11, "noise missing in on time");
    rd(REG_STATUS, 16'h000f, 16'h000e, "duty not off");
    wr(REG_DUTY, 16'h0001);
  endtask

  // Stalled sink: three words held, ready then low, order kept
  task automatic t_stall();
    wr(REG_MODE, 16'h0000);
    stall <= 1'b1;
    @(posedge core_clk);
    model.rx_q.delete();
    for (int i = 0; i < 3; i++) model.push('{20'h00100 + 20'(i), 20'h80000 + 20'(i)});
    @(negedge core_clk);
    check(in_ready === 1'b0, "buffer not full");
    @(posedge core_clk);
    model.idle();
    stall <= 1'b0;
    repeat (8) @(posedge core_clk);
    check(model.rx_q.size() == 3, "stalled words lost");
    foreach (model.rx_q[i]) check(model.rx_q[i] === {20'h00100 + 20'(i), 20'h80000 + 20'(i)}, "order");
  endtask

  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stall = 1'b0;
    resetn = 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    run(3'h0, 16'h2000, 16'h4000, 2'd0, 2'd0, "passthrough");
    run(3'h1, 16'h0000, 16'h4000, 2'd0, 2'd0, "zero atten");
    run(3'h1, 16'h2000, 16'h0000, 2'd1, 2'd0, "pre insert");
    run(3'h2, 16'h2000, 16'h0000, 2'd0, 2'd1, "post insert");
    run(3'h5, 16'h2000, 16'h0000, 2'd0, 2'd0, "noise volume zero");
    run(3'h5, 16'h2000, 16'h4000, 2'd1, 2'd0, "noise volume unity");
    run(3'h3, 16'h2000, 16'h4000, 2'd3, 2'd2, "noise only pre");
    run(3'h4, 16'h2000, 16'h4000, 2'd2, 2'd3, "noise only post");
    t_duty();
    t_stall();
    results();
  end
endmodule
`default_nettype wire
